// File: logic/cims_top.sv
// Function
// - two software and six hardware requests; timer and counter merge into request five
// - compatibility mode dispatches unvectored at offset 0x180 or 0x200 by vector select
// - interrupt taken only with request, enable set, no exception, error or debug
// - boot select set, vector select clear or zero spacing forces compatibility mode
// - vectored mode needs vectored support present and no external controller
// - external controller mode whenever that controller is present and selected
// - vector spacing held at zero when no vectored mode is implemented
// - reset leaves the block in compatibility mode
// - cause reads always show the live pending request bits
// - each request is pending bit AND mask bit, seven down to zero
// - non-maskable event pulses nmi_exception past every enable and mask, changes no control field, sets its event status bit; irq needs its event enable bit
// - vectored mode picks highest set masked request as vector number
`timescale 1ns/100ps
module cims_top #(
	parameter bit VECTORED_PRESENT = 1'b1,
	parameter bit EXTERNAL_PRESENT = 1'b0,
	parameter bit DEBUG_PRESENT = 1'b1
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [cims_pkg::CIMS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [cims_pkg::CIMS_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [cims_pkg::CIMS_ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [cims_pkg::CIMS_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic [5:0] hw_request,
	input wire logic timer_request,
	input wire logic perf_counter_request,
	input wire logic nmi_request,
	input wire logic [cims_pkg::CIMS_LEVEL_W-1:0] external_request_level,
	output logic interrupt_request,
	output cims_pkg::cims_mode_e interrupt_mode,
	output logic [cims_pkg::CIMS_LEVEL_W-1:0] vector_number,
	output logic [cims_pkg::CIMS_OFF_W-1:0] vector_offset,
	output logic nmi_exception,
	output logic irq
);
	import cims_pkg::*;

	localparam bit VS_ALLOWED = VECTORED_PRESENT | EXTERNAL_PRESENT;

	typedef struct packed {
		logic aw_rdy;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_rdy;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic gie;
		logic exception_level;
		logic error_level;
		logic dm;
		logic boot_exception_vector_select;
		logic iv;
		logic [4:0] vs;
		logic [7:0] mask;
		logic [1:0] sw;
		logic [7:0] pending;
		logic [1:0] evt_status;
		logic [1:0] evt_enable;
		logic take_prev;
		logic nmi_prev;
		logic take;
		cims_mode_e mode;
		logic [5:0] vnum;
		logic [11:0] voff;
		logic nmi_pulse;
		logic irq;
	} cims_state_s;

	cims_state_s st_q;
	cims_state_s st_d;

	cims_core_if core_bus ();

	cims_decode #(
		.VECTORED_PRESENT(VECTORED_PRESENT),
		.EXTERNAL_PRESENT(EXTERNAL_PRESENT),
		.DEBUG_PRESENT(DEBUG_PRESENT)
	) u_decode (
		.bus(core_bus)
	);

	assign core_bus.pending = st_q.pending;
	assign core_bus.mask = st_q.mask;
	assign core_bus.gie = st_q.gie;
	assign core_bus.exception_level = st_q.exception_level;
	assign core_bus.error_level = st_q.error_level;
	assign core_bus.dm = st_q.dm;
	assign core_bus.boot_exception_vector_select = st_q.boot_exception_vector_select;
	assign core_bus.iv = st_q.iv;
	assign core_bus.vs = st_q.vs;
	assign core_bus.ext_level = external_request_level;

	function automatic logic [31:0] merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] strb
	);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction

	function automatic logic [31:0] control_word(input cims_state_s s);
		logic [31:0] w;
		w = 32'h00000000;
		w[CIMS_GIE_BIT] = s.gie;
		w[CIMS_EXL_BIT] = s.exception_level;
		w[CIMS_ERL_BIT] = s.error_level;
		w[CIMS_DM_BIT] = s.dm;
		w[CIMS_BEV_BIT] = s.boot_exception_vector_select;
		w[CIMS_IV_BIT] = s.iv;
		w[CIMS_VS_LSB +: CIMS_VS_W] = s.vs;
		return w;
	endfunction

	logic [31:0] wword;
	logic [31:0] rword;
	logic rmapped;
	logic wmapped;
	logic [1:0] evt_set;
	logic [1:0] evt_clr;

	always_comb
	begin
		wword = 32'h00000000;
		rword = 32'h00000000;
		rmapped = 1'b1;
		wmapped = 1'b1;
		evt_set = 2'h0;
		evt_clr = 2'h0;
		st_d = st_q;

		// live request sampling, timer and counter folded into the top line
		st_d.pending = {hw_request[5] | timer_request | perf_counter_request,
			hw_request[4:0], st_q.sw};

		// decoded results registered so every output leaves a flop
		st_d.mode = core_bus.mode;
		st_d.take = core_bus.request;
		st_d.vnum = core_bus.vnum;
		st_d.voff = core_bus.voff;
		st_d.take_prev = st_q.take;

		// nmi never looks at enables or masks and touches no control field
		st_d.nmi_prev = nmi_request;
		st_d.nmi_pulse = nmi_request & ~st_q.nmi_prev;

		evt_set[CIMS_EVT_TAKE] = st_q.take & ~st_q.take_prev;
		evt_set[CIMS_EVT_NMI] = nmi_request & ~st_q.nmi_prev;

		// write address and data may come in either order
		if (s_axi_awvalid && st_q.aw_rdy)
		begin
			st_d.aw_rdy = 1'b0;
			st_d.aw_held = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_q.w_rdy)
		begin
			st_d.w_rdy = 1'b0;
			st_d.w_held = 1'b1;
			st_d.w_data = s_axi_wdata;
			st_d.w_strb = s_axi_wstrb;
		end

		if (st_q.aw_held && st_q.w_held && !st_q.bvalid)
		begin
			st_d.aw_held = 1'b0;
			st_d.w_held = 1'b0;
			st_d.bvalid = 1'b1;
			unique case (st_q.aw_addr)
				CIMS_CONTROL_OFF:
				begin
					wword = merge(control_word(st_q), st_q.w_data,
						st_q.w_strb);
					st_d.gie = wword[CIMS_GIE_BIT];
					st_d.exception_level = wword[CIMS_EXL_BIT];
					st_d.error_level = wword[CIMS_ERL_BIT];
					st_d.dm = wword[CIMS_DM_BIT];
					st_d.boot_exception_vector_select = wword[CIMS_BEV_BIT];
					st_d.iv = wword[CIMS_IV_BIT];
					// spacing is pinned so no undefined mode can be reached
					st_d.vs = VS_ALLOWED
						? wword[CIMS_VS_LSB +: CIMS_VS_W] : CIMS_VS_RST;
				end
				CIMS_MASK_OFF:
				begin
					wword = merge({22'h000000, st_q.sw, st_q.mask},
						st_q.w_data, st_q.w_strb);
					st_d.mask = wword[7:0];
					st_d.sw = wword[CIMS_SW_LSB +: 2];
				end
				CIMS_EVT_CLEAR_OFF:
					evt_clr = st_q.w_strb[0] ? st_q.w_data[1:0] : 2'h0;
				CIMS_EVT_ENABLE_OFF:
				begin
					if (st_q.w_strb[0])
						st_d.evt_enable = st_q.w_data[1:0];
				end
				default:
					wmapped = 1'b0;
			endcase
			st_d.bresp = wmapped ? CIMS_RESP_OKAY : CIMS_RESP_SLVERR;
		end
		if (st_q.bvalid && s_axi_bready)
		begin
			st_d.bvalid = 1'b0;
			st_d.aw_rdy = 1'b1;
			st_d.w_rdy = 1'b1;
		end

		if (s_axi_arvalid && st_q.ar_rdy)
		begin
			unique case (s_axi_araddr)
				CIMS_CONTROL_OFF:
					rword = control_word(st_q);
				CIMS_MASK_OFF:
					rword = {22'h000000, st_q.sw, st_q.mask};
				CIMS_CAUSE_OFF:
				begin
					// pending bits are the current sample, not a capture
					rword[7:0] = st_q.pending;
					rword[CIMS_MODE_LSB +: 2] = st_q.mode;
					rword[CIMS_REQ_BIT] = st_q.take;
					rword[CIMS_VNUM_LSB +: CIMS_LEVEL_W] = st_q.vnum;
					rword[CIMS_VOFF_LSB +: CIMS_OFF_W] = st_q.voff;
				end
				CIMS_CONFIG_OFF:
					rword = {30'h00000000, EXTERNAL_PRESENT,
						VECTORED_PRESENT};
				CIMS_EVT_STATUS_OFF:
					rword = {30'h00000000, st_q.evt_status};
				CIMS_EVT_CLEAR_OFF:
					rword = 32'h00000000;
				CIMS_EVT_ENABLE_OFF:
					rword = {30'h00000000, st_q.evt_enable};
				default:
					rmapped = 1'b0;
			endcase
			st_d.ar_rdy = 1'b0;
			st_d.rvalid = 1'b1;
			st_d.rdata = rword;
			st_d.rresp = rmapped ? CIMS_RESP_OKAY : CIMS_RESP_SLVERR;
		end
		if (st_q.rvalid && s_axi_rready)
		begin
			st_d.rvalid = 1'b0;
			st_d.ar_rdy = 1'b1;
		end

		// a new event beats a clear arriving in the same cycle
		st_d.evt_status = (st_q.evt_status & ~evt_clr) | evt_set;
		st_d.irq = |(st_d.evt_status & st_d.evt_enable);
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			st_q <= '0;
			st_q.aw_rdy <= 1'b1;
			st_q.w_rdy <= 1'b1;
			st_q.ar_rdy <= 1'b1;
			st_q.gie <= CIMS_GIE_RST;
			st_q.exception_level <= CIMS_EXL_RST;
			st_q.error_level <= CIMS_ERL_RST;
			st_q.dm <= CIMS_DM_RST;
			st_q.boot_exception_vector_select <= CIMS_BEV_RST;
			st_q.iv <= CIMS_IV_RST;
			st_q.vs <= CIMS_VS_RST;
			st_q.mask <= CIMS_MASK_RST;
			st_q.evt_status <= CIMS_EVT_RST;
			st_q.evt_enable <= CIMS_EVT_RST;
			st_q.mode <= mode_compat;
			st_q.voff <= CIMS_GENERAL_OFFSET;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign s_axi_awready = st_q.aw_rdy;
	assign s_axi_wready = st_q.w_rdy;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = st_q.ar_rdy;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign interrupt_request = st_q.take;
	assign interrupt_mode = st_q.mode;
	assign vector_number = st_q.vnum;
	assign vector_offset = st_q.voff;
	assign nmi_exception = st_q.nmi_pulse;
	assign irq = st_q.irq;

endmodule // cims_top

// File: logic/cims_pkg.sv
package cims_pkg;

	localparam int CIMS_ADDR_W = 8;
	localparam int CIMS_DATA_W = 32;
	localparam int CIMS_VS_W = 5;
	localparam int CIMS_LEVEL_W = 6;
	localparam int CIMS_OFF_W = 12;
	localparam int CIMS_EVT_W = 2;

	// register byte offsets
	localparam logic [7:0] CIMS_CONTROL_OFF = 8'h00;
	localparam logic [7:0] CIMS_MASK_OFF = 8'h04;
	localparam logic [7:0] CIMS_CAUSE_OFF = 8'h08;
	localparam logic [7:0] CIMS_CONFIG_OFF = 8'h0C;
	localparam logic [7:0] CIMS_EVT_STATUS_OFF = 8'h10;
	localparam logic [7:0] CIMS_EVT_CLEAR_OFF = 8'h14;
	localparam logic [7:0] CIMS_EVT_ENABLE_OFF = 8'h18;

	// control register field positions
	localparam int CIMS_GIE_BIT = 0;
	localparam int CIMS_EXL_BIT = 1;
	localparam int CIMS_ERL_BIT = 2;
	localparam int CIMS_DM_BIT = 3;
	localparam int CIMS_BEV_BIT = 4;
	localparam int CIMS_IV_BIT = 5;
	localparam int CIMS_VS_LSB = 6;

	// mask register: mask in 7:0, software requests in 9:8
	localparam int CIMS_SW_LSB = 8;

	// cause register field positions
	localparam int CIMS_MODE_LSB = 8;
	localparam int CIMS_REQ_BIT = 10;
	localparam int CIMS_VNUM_LSB = 12;
	localparam int CIMS_VOFF_LSB = 18;

	// event bits
	localparam int CIMS_EVT_TAKE = 0;
	localparam int CIMS_EVT_NMI = 1;

	// reset values: boot vector select set puts the block in compatibility
	localparam logic CIMS_GIE_RST = 1'b0;
	localparam logic CIMS_EXL_RST = 1'b0;
	localparam logic CIMS_ERL_RST = 1'b1;
	localparam logic CIMS_DM_RST = 1'b0;
	localparam logic CIMS_BEV_RST = 1'b1;
	localparam logic CIMS_IV_RST = 1'b0;
	localparam logic [4:0] CIMS_VS_RST = 5'h00;
	localparam logic [7:0] CIMS_MASK_RST = 8'h00;
	localparam logic [1:0] CIMS_EVT_RST = 2'h0;

	localparam logic [11:0] CIMS_GENERAL_OFFSET = 12'h180;
	localparam logic [11:0] CIMS_SPECIAL_OFFSET = 12'h200;

	localparam logic [1:0] CIMS_RESP_OKAY = 2'h0;
	localparam logic [1:0] CIMS_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		mode_compat,
		mode_vectored,
		mode_external
	} cims_mode_e;

endpackage

// File: logic/cims_core_if.sv
`timescale 1ns/100ps
interface cims_core_if;
	import cims_pkg::*;
	logic [7:0] pending;
	logic [7:0] mask;
	logic gie;
	logic exception_level;
	logic error_level;
	logic dm;
	logic boot_exception_vector_select;
	logic iv;
	logic [4:0] vs;
	logic [5:0] ext_level;
	cims_mode_e mode;
	logic request;
	logic [5:0] vnum;
	logic [11:0] voff;

	modport core (
		output pending, mask, gie, exception_level, error_level, dm, boot_exception_vector_select, iv, vs, ext_level,
		input mode, request, vnum, voff
	);
	modport dec (
		input pending, mask, gie, exception_level, error_level, dm, boot_exception_vector_select, iv, vs, ext_level,
		output mode, request, vnum, voff
	);
endinterface

// File: logic/cims_decode.sv
`timescale 1ns/100ps
module cims_decode #(
	parameter bit VECTORED_PRESENT = 1'b1,
	parameter bit EXTERNAL_PRESENT = 1'b0,
	parameter bit DEBUG_PRESENT = 1'b1
) (
	cims_core_if.dec bus
);
	import cims_pkg::*;

	logic [7:0] svc;
	logic compat;
	logic mode_req;
	logic enabled;

	always_comb
	begin
		svc = bus.pending & bus.mask;
		compat = bus.boot_exception_vector_select | ~bus.iv | (bus.vs == 5'h00);
		if (compat)
			bus.mode = mode_compat;
		else if (EXTERNAL_PRESENT)
			bus.mode = mode_external;
		else if (VECTORED_PRESENT)
			bus.mode = mode_vectored;
		else
			bus.mode = mode_compat;
		// external mode takes its request level from the outside controller
		if (bus.mode == mode_external)
			mode_req = (bus.ext_level != 6'h00);
		else
			mode_req = |svc;
		enabled = bus.gie & ~bus.exception_level & ~bus.error_level
			& ~(bus.dm & DEBUG_PRESENT);
		bus.request = mode_req & enabled;
		bus.vnum = 6'h00;
		if (bus.mode == mode_external)
			bus.vnum = bus.ext_level;
		else if (bus.mode == mode_vectored)
		begin
			// ascending loop so the highest set bit wins
			for (int i = 0; i < 8; i++)
			begin
				if (svc[i])
					bus.vnum = 6'(i);
			end
		end
		// compatibility dispatch offset from the vector select
		bus.voff = bus.iv ? CIMS_SPECIAL_OFFSET : CIMS_GENERAL_OFFSET;
	end

endmodule // cims_decode

// File: verif/cims_src_model.sv
`timescale 1ns/100ps
module cims_src_model (
	input wire logic core_clk,
	input wire logic [8:0] cmd,
	output logic [5:0] hw_request,
	output logic timer_request,
	output logic perf_counter_request,
	output logic nmi_request,
	output logic [5:0] external_request_level
);
	// no outside controller fitted, so its level stays quiet
	assign external_request_level = 6'h00;
	// sources move only just after an edge, like real synchronous levels
	always @(posedge core_clk)
		{nmi_request, perf_counter_request, timer_request, hw_request} <= cmd;
endmodule // cims_src_model

// File: verif/cims_top_checker.sv
`timescale 1ns/100ps
module cims_top_checker
	import cims_pkg::*;
#(
	parameter bit EXTERNAL_PRESENT = 1'b0
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic nmi_request,
	input wire logic nmi_exception,
	input wire logic interrupt_request,
	input wire cims_pkg::cims_mode_e interrupt_mode,
	input wire logic [5:0] vector_number,
	input wire logic [11:0] vector_offset,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	AST_RST_QUIET: assert property ($fell(reset) |-> !interrupt_request [*3])
		else $error("request raised right after reset");
	AST_RST_MODE: assert property ($fell(reset) |->
		(interrupt_mode == mode_compat && vector_offset == CIMS_GENERAL_OFFSET) [*3])
		else $error("not in compatibility mode after reset");
	AST_NMI: assert property ($rose(nmi_request) |-> ##[1:2] nmi_exception)
		else $error("nmi exception missing");
	AST_NMI_ONE: assert property (nmi_exception |=> !nmi_exception)
		else $error("nmi exception longer than one cycle");
	AST_VOFF: assert property (vector_offset == CIMS_GENERAL_OFFSET ||
		vector_offset == CIMS_SPECIAL_OFFSET)
		else $error("vector offset out of set");
	AST_MODE_SET: assert property (interrupt_mode != 2'h3 &&
		(EXTERNAL_PRESENT || interrupt_mode != mode_external))
		else $error("impossible interrupt mode");
	AST_VNUM: assert property (interrupt_mode == mode_vectored |-> vector_number <= 6'h07)
		else $error("vector number above seven");
	AST_COMPAT_VNUM: assert property (interrupt_mode == mode_compat &&
		$stable(interrupt_mode) |-> vector_number == 6'h00)
		else $error("vector number in compatibility mode");
	AST_RVALID: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
endmodule // cims_top_checker

bind cims_top cims_top_checker #(.EXTERNAL_PRESENT(EXTERNAL_PRESENT)) cims_top_checker_i (
	.core_clk(core_clk),
	.reset(reset),
	.nmi_request(nmi_request),
	.nmi_exception(nmi_exception),
	.interrupt_request(interrupt_request),
	.interrupt_mode(interrupt_mode),
	.vector_number(vector_number),
	.vector_offset(vector_offset),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata)
);

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import cims_pkg::*;
	logic core_clk, reset, awv, awr, wv, wrd, bv, bb, arv, arr, rv, rb;
	logic [7:0] awa, ara, rs;
	logic [31:0] wd, rdt, ctl;
	logic [1:0] bp, rp;
	logic [5:0] hw, elv, vnum;
	logic [11:0] voff;
	logic tmr, pfc, nmi, ireq, nmx, irq, ie, smp;
	cims_mode_e imode;
	logic [8:0] src;
	logic [9:0] msk;
	logic [33:0] rq[$], bq[$], pq[$];
	logic [10:0] tbl [9] = '{11'h011, 11'h013, 11'h015, 11'h019, 11'h010,
		11'h061, 11'h041, 11'h071, 11'h021};
	int n_fail, n_tests, j, k, n_nmi;
	cims_top cims_top_i (.core_clk(core_clk), .reset(reset),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bb),
		.s_axi_bresp(bp), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rb),
		.s_axi_rdata(rdt), .s_axi_rresp(rp), .hw_request(hw),
		.timer_request(tmr), .perf_counter_request(pfc), .nmi_request(nmi),
		.external_request_level(elv), .interrupt_request(ireq),
		.interrupt_mode(imode), .vector_number(vnum), .vector_offset(voff),
		.nmi_exception(nmx), .irq(irq));
	cims_src_model cims_src_model_i (.core_clk(core_clk), .cmd(src),
		.hw_request(hw), .timer_request(tmr), .perf_counter_request(pfc),
		.nmi_request(nmi), .external_request_level(elv));
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wt(input int i);
		if (i >= 40)
		begin
			n_fail++;
			give_verdict();
		end
	endtask
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] pnd();
		return {src[5] | src[6] | src[7], src[4:0], msk[9:8]};
	endfunction
	function automatic logic [33:0] expv();
		logic [7:0] m;
		logic r, v;
		logic [5:0] n;
		m = pnd() & msk[7:0];
		r = ctl[0] & ~ctl[1] & ~ctl[2] & ~ctl[3] & |m;
		v = ~ctl[4] & ctl[5] & |ctl[10:6];
		n = 6'h00;
		for (int i = 0; i < 8; i++)
			if (v && m[i]) n = i[5:0];
		return {12'h0, ie, r, v ? mode_vectored : mode_compat, n,
			ctl[5] ? CIMS_SPECIAL_OFFSET : CIMS_GENERAL_OFFSET};
	endfunction
	function automatic logic [31:0] cz();
		logic [33:0] e;
		e = expv();
		return {2'h0, e[11:0], e[17:12], 1'b0, e[20], e[19:18], pnd()};
	endfunction
	// an extra edge after each release keeps a following call off this step
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int i;
		bq.push_back({32'h0, r});
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bb <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(posedge core_clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv) break;
		end
		bb <= 1'b0;
		wt(i);
		@(posedge core_clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int i;
		rq.push_back({r, d});
		ara <= a;
		arv <= 1'b1;
		rb <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(posedge core_clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		rb <= 1'b0;
		wt(i);
		@(posedge core_clk);
	endtask
	task automatic look();
		pq.push_back(expv());
		smp <= 1'b1;
		@(posedge core_clk);
		smp <= 1'b0;
		@(posedge core_clk);
	endtask
	always @(posedge core_clk)
	begin
		if (bv && bb) chk({32'h0, bp}, bq.pop_front());
		if (rv && rb) chk({rp, rdt}, rq.pop_front());
		if (smp) chk({12'h0, irq, ireq, imode, vnum, voff}, pq.pop_front());
		// one nmi rise in the run, so exactly one pulse
		if (nmx) n_nmi++;
	end
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		give_verdict();
	end
	initial
	begin
		{reset, awv, wv, bb, arv, rb, smp, ie} = 8'hFF & 8'h80;
		{awa, ara, wd, src, msk, n_fail, n_tests} = '0;
		ctl = 32'h14;
		rs = 8'h12;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rd_reg(CIMS_CONTROL_OFF, 32'h14, CIMS_RESP_OKAY);
		rd_reg(CIMS_CONFIG_OFF, 32'h1, CIMS_RESP_OKAY);
		rd_reg(8'h40, 32'h0, CIMS_RESP_SLVERR);
		wr_reg(CIMS_CAUSE_OFF, 32'hFFFFFFFF, CIMS_RESP_SLVERR);
		rd_reg(CIMS_CAUSE_OFF, cz(), CIMS_RESP_OKAY);
		look();
		for (j = 0; j < 9; j++)
		begin
			ctl = {21'h0, tbl[j]};
			wr_reg(CIMS_CONTROL_OFF, ctl, CIMS_RESP_OKAY);
			for (k = 0; k < 3; k++)
			begin
				rs = lfsr(rs);
				msk = {rs[1:0], rs | 8'h04};
				src = {1'b0, rs[7:6], rs[5:1], 1'b1};
				wr_reg(CIMS_MASK_OFF, {22'h0, msk}, CIMS_RESP_OKAY);
				repeat (5) @(posedge core_clk);
				look();
				rd_reg(CIMS_CAUSE_OFF, cz(), CIMS_RESP_OKAY);
			end
		end
		msk = 10'h000;
		src = 9'h03F;
		wr_reg(CIMS_MASK_OFF, 32'h0, CIMS_RESP_OKAY);
		repeat (5) @(posedge core_clk);
		look();
		msk = 10'h301;
		src = 9'h000;
		wr_reg(CIMS_MASK_OFF, 32'h301, CIMS_RESP_OKAY);
		repeat (5) @(posedge core_clk);
		look();
		ctl = 32'h10;
		wr_reg(CIMS_CONTROL_OFF, ctl, CIMS_RESP_OKAY);
		repeat (3) @(posedge core_clk);
		wr_reg(CIMS_EVT_CLEAR_OFF, 32'h3, CIMS_RESP_OKAY);
		wr_reg(CIMS_EVT_ENABLE_OFF, 32'h2, CIMS_RESP_OKAY);
		// nmi with the gate shut: it must still reach its event
		src[8] = 1'b1;
		repeat (5) @(posedge core_clk);
		ie = 1'b1;
		look();
		rd_reg(CIMS_EVT_STATUS_OFF, 32'h2, CIMS_RESP_OKAY);
		wr_reg(CIMS_EVT_ENABLE_OFF, 32'h1, CIMS_RESP_OKAY);
		ie = 1'b0;
		repeat (2) @(posedge core_clk);
		look();
		wr_reg(CIMS_EVT_CLEAR_OFF, 32'h2, CIMS_RESP_OKAY);
		rd_reg(CIMS_EVT_STATUS_OFF, 32'h0, CIMS_RESP_OKAY);
		ctl = 32'h11;
		wr_reg(CIMS_CONTROL_OFF, ctl, CIMS_RESP_OKAY);
		repeat (5) @(posedge core_clk);
		ie = 1'b1;
		look();
		rd_reg(CIMS_EVT_STATUS_OFF, 32'h1, CIMS_RESP_OKAY);
		chk(34'(n_nmi), 34'h1);
		give_verdict();
	end
endmodule // tb_top
